/* bench/sfwg_host.sv */
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// Host controller model, serial mode 0
// ---------------------------------------------------------------
module sfwg_host (
   output var logic O_SCLK,
   output var logic O_CS_N,
   output var logic O_SI
);
   // Link idles deselected with its clock standing low
   initial begin
      O_SCLK = 1'b0;
      O_CS_N = 1'b1;
      O_SI = 1'b0;
   end
   // MSB first from bit 63; a count of whole bytes ends on a boundary
   task automatic send(input logic [63:0] d, input int n);
      // Called on a rising edge; delays are whole clock periods, so NBAs avoid the race
      O_CS_N <= 1'b0;
      for (int i = 0; i < n; i++) begin
         O_SI <= d[63-i];
         #160 O_SCLK <= 1'b1;
         #160 O_SCLK <= 1'b0;
      end
      #160 O_CS_N <= 1'b1;
      O_SI <= ~O_SI; // Released line must not hold stale data
      #400; // Gap well above the four cycles the receiver needs
   endtask
endmodule
`default_nettype wire

/* bench/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import sfwg_pkg::*;
   logic clk, rst_n, psel, penable, pwrite, lock_n, busy, pready, err, sclk, cs_n, si, st, ablk, wl;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, d;
   sfwg_op_s op;
   int errors = 0;
   int num_checks = 0;
   int n_st = 0;
   localparam int blk [5] = '{0, 15, 16, 30, 31};
   sfwg_guard i_dut (.I_CLK_SYS(clk), .I_RESET_N(rst_n), .I_PSEL(psel), .I_PENABLE(penable),
      .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
      .O_PREADY(pready), .O_PSLVERR(err), .I_SCLK(sclk), .I_CS_N(cs_n), .I_SI(si),
      .I_LOCK_PIN(lock_n), .I_SEQ_BUSY(busy), .O_OP_START(st), .O_OP(op),
      .O_ARRAY_BLOCK(ablk), .O_WRITE_LATCH(wl));
   sfwg_host i_host (.O_SCLK(sclk), .O_CS_N(cs_n), .O_SI(si));
   always #20 clk = ~clk;
   // Start pulses stand one cycle, so count them as they pass
   always @(posedge clk) if (st === 1'b1) n_st++;
   // ---------------------------------------------------------------
   // Access tasks
   // ---------------------------------------------------------------
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e) begin
         errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // Request held until pready is seen high at an edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      d = prdata;
      chk({31'h0, err}, {31'h0, a >= 8'h80 || (a > REG_LAST && a < 8'h40)});
      psel <= 1'b0; penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(d, e);
   endtask
   task automatic cmd(input logic [63:0] f, input int n);
      i_host.send(f, n);
      repeat (4) @(posedge clk);
   endtask
   task automatic last(input logic [7:0] o, input sfwg_rej_e c);
      rd(REG_LAST, {16'h0, o, 4'h0, c});
   endtask
   function automatic logic prot(input int l, input int b);
      if (l == 0) return 1'b0;
      if (l <= 5) return b >= 32 - (1 << (l - 1));
      if (l >= 10 && l <= 14) return b < 32 - (1 << (14 - l));
      return 1'b1;
   endfunction
   task automatic stop_test;
      $display("errors=%0d num_checks=%0d", errors, num_checks);
      if (errors == 0 && num_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // Watchdog far beyond the run of about 40000 cycles
   initial begin
      repeat (60000) @(posedge clk);
      errors++;
      stop_test;
   end
   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      int s;
      clk = 0; rst_n = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
      lock_n = 1; busy = 0;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rd(REG_STATUS, 32'h0);
      cmd({OPC_PAGE_PROG, 24'h1F0003, 8'h55, 24'h0}, 40);
      chk(n_st, 0);
      last(OPC_PAGE_PROG, RJ_LATCH);
      cmd({OPC_SET_LATCH, 56'h0}, 8);
      cmd({OPC_CLR_LATCH, 56'h0}, 7);
      chk({31'h0, wl}, 1);
      cmd({OPC_PAGE_PROG, 24'h1F0003, 8'h55, 24'h0}, 39);
      chk(n_st, 0);
      cmd({OPC_PAGE_PROG, 24'h1F0003, 8'h55, 24'h0}, 40);
      chk({n_st[0], wl}, 2);
      chk(op, {OP_PAGE, 21'h1F0003});
      // Every level against both ends of both halves
      for (int l = 0; l < 16; l++) begin
         cmd({OPC_SET_LATCH, 56'h0}, 8);
         cmd({OPC_STATUS_WR, 2'b00, l[3:0], 2'b00, 48'h0}, 16);
         rd(REG_STATUS, l << 2);
         for (int k = 0; k < 5; k++) begin
            s = n_st;
            cmd({OPC_SET_LATCH, 56'h0}, 8);
            cmd({OPC_SMALL_WIPE, 3'h0, blk[k][4:0], 16'h0, 32'h0}, 32);
            chk({n_st - s, wl}, {!prot(l, blk[k]), prot(l, blk[k])});
         end
      end
      // Level 15 left set and latch still up: whole wipe must be refused
      cmd({OPC_WHOLE_WIPE_B, 56'h0}, 8);
      last(OPC_WHOLE_WIPE_B, RJ_PROTECT);
      cmd({OPC_SET_LATCH, 56'h0}, 8);
      cmd({OPC_STATUS_WR, 8'h84, 48'h0}, 16);
      lock_n <= 1'b0;
      cmd({OPC_SET_LATCH, 56'h0}, 8);
      cmd({OPC_STATUS_WR, 8'h00, 48'h0}, 16);
      rd(REG_STATUS, 32'h86);
      last(OPC_STATUS_WR, RJ_PINLOCK);
      apb(1'b1, REG_CTRL, 32'h1);
      cmd({OPC_STATUS_WR, 8'h00, 48'h0}, 16);
      rd(REG_STATUS, 32'h0);
      lock_n <= 1'b1;
      apb(1'b1, REG_CTRL, 32'h0);
      // Busy sequencer refuses writes; then the other program and erase kinds
      busy <= 1'b1;
      cmd({OPC_SET_LATCH, 56'h0}, 8);
      cmd({OPC_SMALL_WIPE, 24'h0, 32'h0}, 32);
      rd(REG_STATUS, 32'h402);
      last(OPC_SMALL_WIPE, RJ_BUSY);
      busy <= 1'b0;
      s = n_st;
      cmd({OPC_BIG_WIPE, 24'h050000, 32'h0}, 32);
      chk(op, {OP_BIG, 21'h050000});
      cmd({OPC_SET_LATCH, 56'h0}, 8);
      cmd({OPC_CONT_PROG, 24'h000100, 16'hA5A5, 16'h0}, 48);
      chk(op, {OP_CONT, 21'h000100});
      cmd({OPC_SET_LATCH, 56'h0}, 8);
      cmd({OPC_WHOLE_WIPE_A, 56'h0}, 8);
      chk(n_st - s, 3);
      cmd({8'h03, 56'h0}, 8);
      last(8'h03, RJ_UNKNOWN);
      cmd({OPC_SET_LATCH, 56'h0}, 8);
      cmd({OPC_CLR_LATCH, 56'h0}, 8);
      chk({31'h0, wl}, 0);
      cmd({OPC_SLEEP, 56'h0}, 8);
      cmd({OPC_SET_LATCH, 56'h0}, 8);
      rd(REG_STATUS, 32'h100);
      last(OPC_SET_LATCH, RJ_SLEEP);
      cmd({OPC_WAKE_SIG, 56'h0}, 8);
      rd(REG_STATUS, 32'h0);
      s = n_st;
      cmd({OPC_OTP_ENTER, 56'h0}, 8);
      cmd({OPC_SET_LATCH, 56'h0}, 8);
      cmd({OPC_PAGE_PROG, 24'h000011, 8'h5A, 24'h0}, 40);
      cmd({OPC_SET_LATCH, 56'h0}, 8);
      cmd({OPC_SMALL_WIPE, 24'h0, 32'h0}, 32);
      chk({n_st - s, ablk}, 1);
      rd(8'h50, 32'hFFFF5AFF);
      rd(8'h7C, 32'hFFFFFFFF);
      cmd({OPC_OTP_EXIT, 56'h0}, 8);
      chk({31'h0, ablk}, 0);
      cmd({OPC_SET_LATCH, 56'h0}, 8);
      cmd({OPC_SEC_WRITE, 56'h0}, 8);
      rd(REG_SECURITY, 32'h2);
      cmd({OPC_OTP_ENTER, 56'h0}, 8);
      cmd({OPC_PAGE_PROG, 24'h000011, 8'h00, 24'h0}, 40);
      rd(8'h50, 32'hFFFF5AFF);
      last(OPC_PAGE_PROG, RJ_LOCKED);
      cmd({OPC_OTP_EXIT, 56'h0}, 8);
      apb(1'b1, REG_CTRL, 32'h2);
      rd(REG_SECURITY, 32'h3);
      apb(1'b1, REG_CTRL, 32'h0);
      rd(REG_SECURITY, 32'h3);
      rd(8'h30, 32'h0);
      stop_test;
   end
endmodule
`default_nettype wire

/* inc/sfwg_pkg.sv */
`default_nettype none
package sfwg_pkg;

   // ---------------------------------------------------------------
   // Geometry of the array and the secured area
   // ---------------------------------------------------------------
   localparam int SFWG_ADDR_W = 21;
   localparam int SFWG_BLK_LSB = 16;
   localparam int SFWG_BLK_W = 5;
   localparam int SFWG_OTP_BYTES = 64;
   localparam int SFWG_OTP_IDX_W = 6;
   localparam logic [2:0] SFWG_BIT_LAST = 3'h7;
   localparam logic [7:0] SFWG_CNT_MAX = 8'hFF;

   // ---------------------------------------------------------------
   // Opcodes (first byte of a command)
   // ---------------------------------------------------------------
   localparam logic [7:0] OPC_SET_LATCH = 8'h06;
   localparam logic [7:0] OPC_CLR_LATCH = 8'h04;
   localparam logic [7:0] OPC_STATUS_WR = 8'h01;
   localparam logic [7:0] OPC_SMALL_WIPE = 8'h20;
   localparam logic [7:0] OPC_BIG_WIPE = 8'hD8;
   localparam logic [7:0] OPC_WHOLE_WIPE_A = 8'h60;
   localparam logic [7:0] OPC_WHOLE_WIPE_B = 8'hC7;
   localparam logic [7:0] OPC_PAGE_PROG = 8'h02;
   localparam logic [7:0] OPC_CONT_PROG = 8'hAD;
   localparam logic [7:0] OPC_WAKE_SIG = 8'hAB;
   localparam logic [7:0] OPC_SLEEP = 8'hE1;
   localparam logic [7:0] OPC_OTP_ENTER = 8'hE2;
   localparam logic [7:0] OPC_OTP_EXIT = 8'hE3;
   localparam logic [7:0] OPC_SEC_WRITE = 8'hE4;

   // Command lengths in bytes and address byte indices
   localparam logic [7:0] LEN_SINGLE = 8'h01;
   localparam logic [7:0] LEN_STATUS = 8'h02;
   localparam logic [7:0] LEN_ADDR = 8'h04;
   localparam logic [7:0] LEN_PAGE_MIN = 8'h05;
   localparam logic [7:0] LEN_CONT_MIN = 8'h06;
   localparam logic [7:0] IDX_ADDR_HI = 8'h01;
   localparam logic [7:0] IDX_ADDR_MID = 8'h02;
   localparam logic [7:0] IDX_ADDR_LO = 8'h03;

   // ---------------------------------------------------------------
   // Register map and field positions
   // ---------------------------------------------------------------
   localparam logic [7:0] REG_STATUS = 8'h00;
   localparam logic [7:0] REG_CTRL = 8'h04;
   localparam logic [7:0] REG_SECURITY = 8'h08;
   localparam logic [7:0] REG_LAST = 8'h0C;
   localparam logic [1:0] REG_OTP_WIN = 2'h1;
   localparam int ST_WEL_BIT = 1;
   localparam int ST_LVL_LSB = 2;
   localparam int ST_GUARD_BIT = 7;
   localparam int ST_SLEEP_BIT = 8;
   localparam int ST_OTP_BIT = 9;
   localparam int ST_BUSY_BIT = 10;
   localparam int CTRL_QUAD_BIT = 0;
   localparam int CTRL_FLOCK_BIT = 1;
   localparam int SEC_FLOCK_BIT = 0;
   localparam int SEC_CLOCK_BIT = 1;
   localparam int LAST_OPC_LSB = 8;

   // Protected block set per protect level, bit n is block n
   localparam logic [31:0] SFWG_PROT_MASK [16] = '{
      32'h00000000, 32'h80000000, 32'hC0000000, 32'hF0000000,
      32'hFF000000, 32'hFFFF0000, 32'hFFFFFFFF, 32'hFFFFFFFF,
      32'hFFFFFFFF, 32'hFFFFFFFF, 32'h0000FFFF, 32'h00FFFFFF,
      32'h0FFFFFFF, 32'h3FFFFFFF, 32'h7FFFFFFF, 32'hFFFFFFFF};

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [3:0] {
      RJ_NONE, RJ_LENGTH, RJ_SLEEP, RJ_UNKNOWN, RJ_BUSY,
      RJ_LATCH, RJ_PROTECT, RJ_OTP, RJ_PINLOCK, RJ_LOCKED
   } sfwg_rej_e;

   typedef enum logic [2:0] {
      OP_NONE, OP_PAGE, OP_CONT, OP_SMALL, OP_BIG, OP_WHOLE
   } sfwg_op_e;

   typedef struct packed {
      sfwg_op_e kind;
      logic [SFWG_ADDR_W-1:0] addr;
   } sfwg_op_s;

endpackage
`default_nettype wire

/* rtl/sfwg_guard.sv */
// Functional notes
// - After reset the command machine sits in standby and starts nothing.
// - Contents change only after a whole, accepted command sequence.
// - Commands other than wake must be whole bytes ending on a byte boundary, else rejected.
// - Data or status altering commands need the write latch set first.
// - Write latch clears at reset and after clear, status write, program, erase.
// - In deep sleep only wake or signature read is obeyed.
// - Program and erase into the level-protected region are refused.
// - Levels 0 to 5: none, then top 1, 2, 4, 8, 16 blocks.
// - Levels 10 to 14 protect bottom 16..31 blocks; 6-9 and 15 all.
// - Lock pin with guard bit freezes protect level and guard bit.
// - In four-line read mode the lock pin guard is disabled.
// - A separate 512-bit one-time area holds a unique serial number; here the area resets to all ones with no serial in it.
// - Security bit 0 shows the factory lock of the one-time area.
// - Security write command sets the customer lock, security bit 1.
// - Once locked, the secured area and lock state never change again; reset clears both locks and returns the area to all ones.
// - In secured mode no main array operation is started.
// - Bytes 00-0F hold the factory serial, 10-3F customer data; here no serial is preset and page program can write all 64 bytes.
// - 32 blocks of 64 KB, block index from the address top bits.
// - Write-type commands must end on a byte boundary or are rejected.
//
// Local design decisions: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module sfwg_guard
   import sfwg_pkg::*;
(
   input wire logic I_CLK_SYS,
   input wire logic I_RESET_N,
   input wire logic I_PSEL,
   input wire logic I_PENABLE,
   input wire logic I_PWRITE,
   input wire logic [7:0] I_PADDR,
   input wire logic [31:0] I_PWDATA,
   output var logic [31:0] O_PRDATA,
   output var logic O_PREADY,
   output var logic O_PSLVERR,
   input wire logic I_SCLK,
   input wire logic I_CS_N,
   input wire logic I_SI,
   input wire logic I_LOCK_PIN,
   input wire logic I_SEQ_BUSY,
   output var logic O_OP_START,
   output var sfwg_op_s O_OP,
   output var logic O_ARRAY_BLOCK,
   output var logic O_WRITE_LATCH
);

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   logic [2:0] sclk_sync_reg;
   logic [2:0] cs_sync_reg;
   logic [1:0] si_sync_reg;
   logic [1:0] lock_sync_reg;
   logic sclk_rise;
   logic cs_fall;
   logic cs_rise;

   // Bit 0 feeds only bit 1; edges come from the later stages
   always_ff @(posedge I_CLK_SYS) begin
      sclk_sync_reg <= {sclk_sync_reg[1:0], I_SCLK};
      cs_sync_reg <= {cs_sync_reg[1:0], I_CS_N};
      si_sync_reg <= {si_sync_reg[0], I_SI};
      lock_sync_reg <= {lock_sync_reg[0], I_LOCK_PIN};
   end

   assign sclk_rise = sclk_sync_reg[1] & ~sclk_sync_reg[2];
   assign cs_fall = ~cs_sync_reg[1] & cs_sync_reg[2];
   assign cs_rise = cs_sync_reg[1] & ~cs_sync_reg[2];

   // ---------------------------------------------------------------
   // Command framing
   // ---------------------------------------------------------------
   typedef enum {ST_STANDBY, ST_SHIFT, ST_EVAL} sfwg_state_e;
   sfwg_state_e state_reg;
   logic ev;

   // Standby until select falls; evaluate once when it rises
   always_ff @(posedge I_CLK_SYS) begin
      if (!I_RESET_N) begin
         state_reg <= ST_STANDBY;
      end else begin
         unique case (state_reg)
            ST_STANDBY: if (cs_fall) state_reg <= ST_SHIFT;
            ST_SHIFT: if (cs_rise) state_reg <= ST_EVAL;
            ST_EVAL: state_reg <= ST_STANDBY;
         endcase
      end
   end

   assign ev = (state_reg == ST_EVAL);

   logic [6:0] shift_reg;
   logic [2:0] bit_cnt_reg;
   logic [7:0] byte_cnt_reg;
   logic [7:0] opcode_reg;
   logic [7:0] value_reg;
   logic [SFWG_ADDR_W-1:0] addr_reg;
   logic [SFWG_OTP_IDX_W-1:0] otp_ptr_reg;
   logic [SFWG_OTP_BYTES-1:0][7:0] stage_reg;
   logic [SFWG_OTP_BYTES-1:0] stage_vld_reg;
   logic [7:0] byte_val;

   assign byte_val = {shift_reg, si_sync_reg[1]};

   // Deserialiser; data bytes are only staged, never written here
   always_ff @(posedge I_CLK_SYS) begin
      if (!I_RESET_N) begin
         shift_reg <= '0;
         bit_cnt_reg <= '0;
         byte_cnt_reg <= '0;
         opcode_reg <= '0;
         value_reg <= '0;
         addr_reg <= '0;
         otp_ptr_reg <= '0;
         stage_reg <= '0;
         stage_vld_reg <= '0;
      end else if (cs_fall) begin
         bit_cnt_reg <= '0;
         byte_cnt_reg <= '0;
         stage_vld_reg <= '0;
      end else if (state_reg == ST_SHIFT && sclk_rise) begin
         shift_reg <= byte_val[6:0];
         bit_cnt_reg <= bit_cnt_reg + 3'h1;
         if (bit_cnt_reg == SFWG_BIT_LAST) begin
            if (byte_cnt_reg != SFWG_CNT_MAX) byte_cnt_reg <= byte_cnt_reg + 8'h01;
            if (byte_cnt_reg == '0) opcode_reg <= byte_val;
            if (byte_cnt_reg == IDX_ADDR_HI) begin
               value_reg <= byte_val;
               addr_reg[SFWG_ADDR_W-1:16] <= byte_val[SFWG_ADDR_W-17:0];
            end
            if (byte_cnt_reg == IDX_ADDR_MID) addr_reg[15:8] <= byte_val;
            if (byte_cnt_reg == IDX_ADDR_LO) begin
               addr_reg[7:0] <= byte_val;
               otp_ptr_reg <= byte_val[SFWG_OTP_IDX_W-1:0];
            end
            if (byte_cnt_reg > IDX_ADDR_LO) begin
               stage_reg[otp_ptr_reg] <= byte_val; // Wraps inside the area
               stage_vld_reg[otp_ptr_reg] <= 1'b1;
               otp_ptr_reg <= otp_ptr_reg + 1'b1;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Protection state
   // ---------------------------------------------------------------
   logic wel_reg;
   logic sleep_reg;
   logic otp_mode_reg;
   logic [3:0] level_reg;
   logic guard_reg;
   logic quad_reg;
   logic flock_reg;
   logic clock_reg;
   logic [SFWG_OTP_BYTES-1:0][7:0] otp_mem_reg;
   logic pin_lock;
   logic [SFWG_BLK_W-1:0] tgt_blk;
   logic blk_prot;

   assign pin_lock = guard_reg & ~lock_sync_reg[1] & ~quad_reg;
   assign tgt_blk = addr_reg[SFWG_BLK_LSB +: SFWG_BLK_W];
   assign blk_prot = SFWG_PROT_MASK[level_reg][tgt_blk];

   // ---------------------------------------------------------------
   // Command decision
   // ---------------------------------------------------------------
   sfwg_rej_e rej;
   sfwg_op_e op_kind;
   logic [7:0] need_len;
   logic len_is_min;
   logic alters;
   logic known;
   logic is_wake;
   logic len_bad;
   logic acc;

   // Fixed order of checks: framing, sleep, opcode, length, busy, latch, then target
   always_comb begin
      need_len = LEN_SINGLE;
      len_is_min = 1'b0;
      alters = 1'b0;
      known = 1'b1;
      op_kind = OP_NONE;
      case (opcode_reg)
         OPC_SET_LATCH, OPC_CLR_LATCH, OPC_SLEEP, OPC_OTP_ENTER,
         OPC_OTP_EXIT: need_len = LEN_SINGLE;
         OPC_WAKE_SIG: len_is_min = 1'b1; // Signature read may run on
         OPC_SEC_WRITE: alters = 1'b1;
         OPC_STATUS_WR: begin
            need_len = LEN_STATUS;
            alters = 1'b1;
         end
         OPC_WHOLE_WIPE_A, OPC_WHOLE_WIPE_B: begin
            alters = 1'b1;
            op_kind = OP_WHOLE;
         end
         OPC_SMALL_WIPE, OPC_BIG_WIPE: begin
            need_len = LEN_ADDR;
            alters = 1'b1;
            op_kind = (opcode_reg == OPC_SMALL_WIPE) ? OP_SMALL : OP_BIG;
         end
         OPC_PAGE_PROG, OPC_CONT_PROG: begin
            need_len = (opcode_reg == OPC_PAGE_PROG) ? LEN_PAGE_MIN : LEN_CONT_MIN;
            len_is_min = 1'b1;
            alters = 1'b1;
            op_kind = (opcode_reg == OPC_PAGE_PROG) ? OP_PAGE : OP_CONT;
         end
         default: known = 1'b0;
      endcase
      is_wake = (opcode_reg == OPC_WAKE_SIG);
      len_bad = len_is_min ? (byte_cnt_reg < need_len) : (byte_cnt_reg != need_len);
      rej = RJ_NONE;
      if (byte_cnt_reg == '0 || (bit_cnt_reg != '0 && !is_wake)) begin
         rej = RJ_LENGTH;
      end else if (sleep_reg && !is_wake) begin
         rej = RJ_SLEEP;
      end else if (!known) begin
         rej = RJ_UNKNOWN;
      end else if (len_bad) begin
         rej = RJ_LENGTH;
      end else if (alters && I_SEQ_BUSY) begin
         rej = RJ_BUSY;
      end else if (alters && !wel_reg) begin
         rej = RJ_LATCH;
      end else if (otp_mode_reg && op_kind != OP_NONE && op_kind != OP_PAGE) begin
         rej = RJ_OTP;
      end else if (otp_mode_reg && op_kind == OP_PAGE && (flock_reg || clock_reg)) begin
         rej = RJ_LOCKED;
      end else if (opcode_reg == OPC_SEC_WRITE && clock_reg) begin
         rej = RJ_LOCKED;
      end else if (opcode_reg == OPC_STATUS_WR && pin_lock) begin
         rej = RJ_PINLOCK;
      end else if (op_kind == OP_WHOLE && level_reg != '0) begin
         rej = RJ_PROTECT;
      end else if (op_kind != OP_NONE && op_kind != OP_WHOLE && !otp_mode_reg && blk_prot) begin
         rej = RJ_PROTECT;
      end
   end

   assign acc = ev && (rej == RJ_NONE);

   // ---------------------------------------------------------------
   // Write latch, sleep and secured mode
   // ---------------------------------------------------------------
   always_ff @(posedge I_CLK_SYS) begin
      if (!I_RESET_N) begin
         wel_reg <= 1'b0;
         sleep_reg <= 1'b0;
         otp_mode_reg <= 1'b0;
      end else if (acc) begin
         if (opcode_reg == OPC_SET_LATCH) wel_reg <= 1'b1;
         if (opcode_reg == OPC_CLR_LATCH || opcode_reg == OPC_STATUS_WR ||
             op_kind != OP_NONE) wel_reg <= 1'b0;
         if (opcode_reg == OPC_SLEEP) sleep_reg <= 1'b1;
         if (is_wake) sleep_reg <= 1'b0;
         if (opcode_reg == OPC_OTP_ENTER) otp_mode_reg <= 1'b1;
         if (opcode_reg == OPC_OTP_EXIT) otp_mode_reg <= 1'b0;
      end
   end

   // Protect level and guard bit: only an accepted status write moves them
   always_ff @(posedge I_CLK_SYS) begin
      if (!I_RESET_N) begin
         level_reg <= '0;
         guard_reg <= 1'b0;
      end else if (acc && opcode_reg == OPC_STATUS_WR) begin
         level_reg <= value_reg[ST_LVL_LSB +: 4];
         guard_reg <= value_reg[ST_GUARD_BIT];
      end
   end

   // ---------------------------------------------------------------
   // Secured one-time area
   // ---------------------------------------------------------------
   // Programming only clears bits, like a real cell; locks are set-only
   always_ff @(posedge I_CLK_SYS) begin
      if (!I_RESET_N) begin
         clock_reg <= 1'b0;
         otp_mem_reg <= '1; // Erased state; contents not kept over reset
      end else if (acc) begin
         if (opcode_reg == OPC_SEC_WRITE) clock_reg <= 1'b1;
         if (otp_mode_reg && op_kind == OP_PAGE) begin
            for (int i = 0; i < SFWG_OTP_BYTES; i++) begin
               if (stage_vld_reg[i]) otp_mem_reg[i] <= otp_mem_reg[i] & stage_reg[i];
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Sequencer request
   // ---------------------------------------------------------------
   logic op_start_reg;
   sfwg_op_s op_reg;
   sfwg_rej_e last_rej_reg;
   logic [7:0] last_opc_reg;

   // Refused commands never pulse start, so busy stays clear
   always_ff @(posedge I_CLK_SYS) begin
      if (!I_RESET_N) begin
         op_start_reg <= 1'b0;
         op_reg <= '{kind: OP_NONE, addr: '0};
      end else begin
         op_start_reg <= acc && op_kind != OP_NONE && !otp_mode_reg;
         if (acc && op_kind != OP_NONE && !otp_mode_reg) begin
            op_reg <= '{kind: op_kind, addr: addr_reg};
         end
      end
   end

   // Outcome of the most recent command for software
   always_ff @(posedge I_CLK_SYS) begin
      if (!I_RESET_N) begin
         last_rej_reg <= RJ_NONE;
         last_opc_reg <= '0;
      end else if (ev) begin
         last_rej_reg <= rej;
         last_opc_reg <= opcode_reg;
      end
   end

   // ---------------------------------------------------------------
   // APB slave, one wait state
   // ---------------------------------------------------------------
   logic pready_reg;
   logic pslverr_reg;
   logic [31:0] prdata_reg;
   logic [31:0] rdata_next;
   logic hit;
   logic wr_go;

   // Read mux; the otp window is read-only
   always_comb begin
      rdata_next = '0;
      hit = 1'b1;
      if (I_PADDR[7:6] == REG_OTP_WIN) begin
         rdata_next = otp_mem_reg[{I_PADDR[5:2], 2'h0} +: 4];
      end else begin
         unique case (I_PADDR)
            REG_STATUS: begin
               rdata_next[ST_WEL_BIT] = wel_reg;
               rdata_next[ST_LVL_LSB +: 4] = level_reg;
               rdata_next[ST_GUARD_BIT] = guard_reg;
               rdata_next[ST_SLEEP_BIT] = sleep_reg;
               rdata_next[ST_OTP_BIT] = otp_mode_reg;
               rdata_next[ST_BUSY_BIT] = I_SEQ_BUSY | op_start_reg;
            end
            REG_CTRL: begin
               rdata_next[CTRL_QUAD_BIT] = quad_reg;
               rdata_next[CTRL_FLOCK_BIT] = flock_reg;
            end
            REG_SECURITY: begin
               rdata_next[SEC_FLOCK_BIT] = flock_reg;
               rdata_next[SEC_CLOCK_BIT] = clock_reg;
            end
            REG_LAST: rdata_next = {16'h0000, last_opc_reg, 4'h0, last_rej_reg};
            default: hit = 1'b0;
         endcase
      end
   end

   // Answer in the second access cycle
   always_ff @(posedge I_CLK_SYS) begin
      if (!I_RESET_N) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= '0;
      end else begin
         pready_reg <= I_PSEL & I_PENABLE & ~pready_reg;
         if (I_PSEL && I_PENABLE && !pready_reg) begin
            pslverr_reg <= ~hit;
            prdata_reg <= I_PWRITE ? 32'h00000000 : rdata_next;
         end else begin
            pslverr_reg <= 1'b0;
         end
      end
   end

   assign wr_go = I_PSEL & I_PENABLE & pready_reg & I_PWRITE;

   // Control: quad mode flag and set-only factory lock
   always_ff @(posedge I_CLK_SYS) begin
      if (!I_RESET_N) begin
         quad_reg <= 1'b0;
         flock_reg <= 1'b0;
      end else if (wr_go && I_PADDR == REG_CTRL) begin
         quad_reg <= I_PWDATA[CTRL_QUAD_BIT];
         if (I_PWDATA[CTRL_FLOCK_BIT]) flock_reg <= 1'b1;
      end
   end

   assign O_PRDATA = prdata_reg;
   assign O_PREADY = pready_reg;
   assign O_PSLVERR = pslverr_reg;
   assign O_OP_START = op_start_reg;
   assign O_OP = op_reg;
   assign O_ARRAY_BLOCK = otp_mode_reg;
   assign O_WRITE_LATCH = wel_reg;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge I_CLK_SYS); endclocking
   default disable iff (!I_RESET_N);

   a_reset_to_standby: assert property ($rose(I_RESET_N) |-> state_reg == ST_STANDBY && !wel_reg)
      else $error("not in standby after reset");
   a_start_needs_latch: assert property (op_start_reg |-> $past(wel_reg) && !wel_reg)
      else $error("start without latch or latch kept");
   a_length_reject: assert property (ev && bit_cnt_reg != '0 && !is_wake |=> !op_start_reg ##0 last_rej_reg == RJ_LENGTH)
      else $error("ragged command not rejected");
   a_sleep_ignore: assert property (ev && sleep_reg && !is_wake |=> sleep_reg && !op_start_reg && $stable(wel_reg))
      else $error("command obeyed in sleep");
   a_protect_block: assert property (op_start_reg && O_OP.kind != OP_WHOLE |-> !SFWG_PROT_MASK[level_reg][O_OP.addr[SFWG_BLK_LSB +: SFWG_BLK_W]])
      else $error("protected block started");
   a_pin_lock_hold: assert property (ev && pin_lock |=> $stable(level_reg) && $stable(guard_reg))
      else $error("status changed under pin lock");
   a_otp_no_array: assert property (op_start_reg |-> !otp_mode_reg && !$past(otp_mode_reg, 2))
      else $error("array op in secured mode");
   a_lock_frozen: assert property ((flock_reg || clock_reg) |=> $stable(otp_mem_reg) && $past(clock_reg) <= clock_reg)
      else $error("locked area changed");
   a_apb_one_wait: assert property (I_PSEL && I_PENABLE && !pready_reg |=> pready_reg ##1 !pready_reg)
      else $error("apb answer timing");

   c_page_started: cover property (op_start_reg && O_OP.kind == OP_PAGE);
   c_sleep_wake: cover property (sleep_reg ##[1:400] !sleep_reg);
   c_otp_program: cover property (acc && otp_mode_reg && op_kind == OP_PAGE);
   c_protect_refused: cover property (ev && rej == RJ_PROTECT);

endmodule
`default_nettype wire
